// ===== design/frf_device.sv
// device end: reset pin handling, unique id read and parameter table read
// assumes mode 0 framing: clock low at select, data sampled on rising edge
// Contract
// - reset pin low 10 us resets to standby
// - hardware reset restores all volatile bits
// - reset aborts running program or erase
// - data out undriven while reset held
// - host waits 30 us or 120 ms
// - reset high 10 us before select
// - unique id read returns 128-bit identifier
// - table read: 5Ah, address, dummy, data
// - select high ends table read anytime
// - signature, revisions and header count bytes
// - bytes 07h, 0Fh, 17h read FFh
// - first header: id 00, 1.0, 09h, 30h
// - second header: vendor, 1.0, 03h, 60h
`timescale 1ns/1ps
`default_nettype none
module frf_device #(
    parameter logic [127:0] UNIQUE_ID = 128'h0123456789abcdef0f1e2d3c4b5a6978,
    parameter logic [7:0] VENDOR_ID = 8'h3c, // arbitrary value
    parameter int RESET_LOW_CYC = frf_pkg::RESET_LOW_CYC
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    frf_link_if.dev link,
    input wire logic i_pe_busy,
    output logic o_pe_abort,
    output logic o_vol_reset,
    output logic o_in_reset,
    output logic o_busy
);

    initial begin
        if (RESET_LOW_CYC < 1 || RESET_LOW_CYC > 255) begin
            $error("reset low count out of range");
        end
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_SKIP
    } frf_dev_st_t;

    typedef struct packed {
        logic [3:0] s1; // first synchroniser stage
        logic [3:0] s2; // second stage: rst_n, cs_n, sclk, si
        logic sck_prev;
        frf_dev_st_t st;
        logic [2:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic [7:0] sh_in;
        logic is_uid;
        logic [23:0] addr;
        logic [1:0][7:0] buf_mem;
        logic buf_wp;
        logic buf_rp;
        logic [1:0] buf_cnt;
        logic [7:0] sh_out;
        logic so;
        logic [7:0] rst_cnt;
        logic pe_abort;
        logic vol_reset;
    } frf_dev_state_t;

    frf_dev_state_t q, d;

    ////////////////////////////////////////////////////////////////////////
    // table and identifier lookup

    function automatic logic [7:0] frf_table_byte(input logic [23:0] a);
        logic [7:0] v;
        v = frf_pkg::TBL_UNUSED;
        if (a[23:5] == 19'h0) begin
            case (a[4:0])
                5'h00: v = frf_pkg::TBL_SIGNATURE[7:0];
                5'h01: v = frf_pkg::TBL_SIGNATURE[15:8];
                5'h02: v = frf_pkg::TBL_SIGNATURE[23:16];
                5'h03: v = frf_pkg::TBL_SIGNATURE[31:24];
                5'h04: v = frf_pkg::TBL_MINOR_REV;
                5'h05: v = frf_pkg::TBL_MAJOR_REV;
                5'h06: v = frf_pkg::TBL_HEADER_COUNT;
                5'h07: v = frf_pkg::TBL_UNUSED;
                5'h08: v = frf_pkg::HDR0_ID;
                5'h09: v = frf_pkg::TBL_MINOR_REV;
                5'h0a: v = frf_pkg::TBL_MAJOR_REV;
                5'h0b: v = frf_pkg::HDR0_LEN_DW;
                5'h0c: v = frf_pkg::HDR0_TABLE_POINTER;
                5'h0d: v = 8'h00;
                5'h0e: v = 8'h00;
                5'h0f: v = frf_pkg::TBL_UNUSED;
                5'h10: v = VENDOR_ID;
                5'h11: v = frf_pkg::TBL_MINOR_REV;
                5'h12: v = frf_pkg::TBL_MAJOR_REV;
                5'h13: v = frf_pkg::HDR1_LEN_DW;
                5'h14: v = frf_pkg::HDR1_TABLE_POINTER;
                5'h15: v = 8'h00;
                5'h16: v = 8'h00;
                5'h17: v = frf_pkg::TBL_UNUSED;
                default: v = frf_pkg::TBL_UNUSED;
            endcase
        end
        // the table bodies beyond the headers live elsewhere and read FFh
        return v;
    endfunction : frf_table_byte

    // identifier goes out most significant byte first, wrapping every 16
    function automatic logic [7:0] frf_uid_byte(input logic [3:0] idx);
        logic [127:0] sh;
        sh = UNIQUE_ID << {idx, 3'b000};
        return sh[127:120];
    endfunction : frf_uid_byte

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic rst_pin;
    logic cs_n;
    logic sck;
    logic si;
    logic sck_rise;
    logic sck_fall;
    logic [7:0] byte_in;

    assign rst_pin = q.s2[3];
    assign cs_n = q.s2[2];
    assign sck = q.s2[1];
    assign si = q.s2[0];
    assign sck_rise = sck && !q.sck_prev;
    assign sck_fall = !sck && q.sck_prev;
    assign byte_in = {q.sh_in[6:0], si};

    always_comb begin
        d = q;
        d.s1 = {link.rst_n, link.cs_n, link.sclk, link.si};
        d.s2 = q.s1;
        d.sck_prev = sck;
        d.pe_abort = 1'b0;
        d.vol_reset = 1'b0;

        if (!rst_pin) begin
            // reset held: link logic parked, output released
            d.st = ST_IDLE;
            d.bit_cnt = 3'h0;
            d.buf_cnt = 2'h0;
            if (q.rst_cnt != 8'(RESET_LOW_CYC)) begin
                d.rst_cnt = q.rst_cnt + 8'h1;
            end
            if (q.rst_cnt == 8'(RESET_LOW_CYC - 1)) begin
                // pulse is long enough: back to standby defaults
                d.vol_reset = 1'b1;
                d.pe_abort = i_pe_busy;
                d.so = 1'b0;
                d.sh_out = 8'h00;
                d.addr = 24'h0;
                d.is_uid = 1'b0;
            end
        end else if (cs_n) begin
            // deselect ends any command at once, even mid byte
            d.rst_cnt = 8'h0;
            d.st = ST_IDLE;
            d.bit_cnt = 3'h0;
            d.buf_cnt = 2'h0;
            d.buf_wp = 1'b0;
            d.buf_rp = 1'b0;
        end else begin
            d.rst_cnt = 8'h0;
            if (q.st == ST_IDLE) begin
                d.st = ST_CMD;
                d.bit_cnt = 3'h0;
                d.byte_cnt = 2'h0;
            end
            // input bits on the rising clock edge
            if (sck_rise && q.st != ST_IDLE && q.st != ST_DATA) begin
                d.sh_in = byte_in;
                d.bit_cnt = q.bit_cnt + 3'h1;
                if (q.bit_cnt == 3'h7) begin
                    d.byte_cnt = q.byte_cnt + 2'h1;
                    case (q.st)
                        ST_CMD: begin
                            d.byte_cnt = 2'h0;
                            if (byte_in == frf_pkg::READ_PARAM_TABLE_CMD) begin
                                d.st = ST_ADDR;
                                d.is_uid = 1'b0;
                            end else if (byte_in == frf_pkg::READ_UNIQUE_ID_CMD)
                            begin
                                d.st = ST_DUMMY;
                                d.is_uid = 1'b1;
                            end else begin
                                d.st = ST_SKIP;
                            end
                        end
                        ST_ADDR: begin
                            d.addr = {q.addr[15:0], byte_in};
                            if (q.byte_cnt == 2'(frf_pkg::ADDR_BYTES - 1)) begin
                                d.st = ST_DUMMY;
                                d.byte_cnt = 2'h0;
                            end
                        end
                        ST_DUMMY: begin
                            if (!q.is_uid || q.byte_cnt ==
                                2'(frf_pkg::UID_DUMMY_BYTES - 1)) begin
                                d.st = ST_DATA;
                                if (q.is_uid) begin
                                    d.addr = 24'h0;
                                end
                                d.buf_cnt = 2'h0;
                                d.buf_wp = 1'b0;
                                d.buf_rp = 1'b0;
                            end
                        end
                        default: d.st = q.st;
                    endcase
                end
            end
            // output bits change on the falling clock edge
            if (sck_fall && q.st == ST_DATA) begin
                d.bit_cnt = q.bit_cnt + 3'h1;
                if (q.bit_cnt == 3'h0) begin
                    // an empty buffer cannot occur at this clock rate
                    if (q.buf_cnt != 2'h0) begin
                        d.so = q.buf_mem[q.buf_rp][7];
                        d.sh_out = {q.buf_mem[q.buf_rp][6:0], 1'b0};
                        d.buf_rp = !q.buf_rp;
                        d.buf_cnt = q.buf_cnt - 2'h1;
                    end else begin
                        d.so = 1'b1;
                        d.sh_out = 8'hfe;
                    end
                end else begin
                    d.so = q.sh_out[7];
                    d.sh_out = {q.sh_out[6:0], 1'b0};
                end
            end
            // byte source fills the two-entry buffer while it has room
            if (q.st == ST_DATA && d.buf_cnt != 2'h2) begin
                d.buf_mem[q.buf_wp] = q.is_uid ? frf_uid_byte(q.addr[3:0])
                                              : frf_table_byte(q.addr);
                d.buf_wp = !q.buf_wp;
                d.buf_cnt = d.buf_cnt + 2'h1;
                d.addr = q.addr + 24'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '0;
            // idle pin levels, so no false clock edge follows reset
            q.s1 <= 4'hc;
            q.s2 <= 4'hc;
            q.st <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // drive only during data out with reset high and select low
    assign link.so = q.so;
    assign link.so_oe = (q.st == ST_DATA) && !cs_n && rst_pin;
    assign o_pe_abort = q.pe_abort;
    assign o_vol_reset = q.vol_reset;
    assign o_in_reset = !rst_pin;
    assign o_busy = q.st != ST_IDLE;

endmodule : frf_device
`default_nettype wire

// ===== design/frf_pkg.sv
// constants shared by both ends of the flash reset / unique id / table link
// assumes a 10 MHz system clock on each end
package frf_pkg;

    // system clock
    localparam int CLK_NS = 100;

    // reset pin timing, least times round up to whole cycles
    localparam int RESET_LOW_WIDTH_NS = 10000;
    localparam int RESET_LOW_CYC = (RESET_LOW_WIDTH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_HIGH_TO_SELECT_NS = 10000;
    localparam int RESET_HIGH_TO_SELECT_CYC =
        (RESET_HIGH_TO_SELECT_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_RECOVERY_NS = 30000;
    localparam int RESET_RECOVERY_CYC =
        (RESET_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_RECOVERY_LONG_MS = 120;
    localparam int RESET_RECOVERY_LONG_CYC =
        RESET_RECOVERY_LONG_MS * (1000000 / CLK_NS);

    // serial clock half period in system cycles (800 ns period)
    localparam int SCLK_HALF_CYC = 4;

    // opcodes
    localparam logic [7:0] READ_PARAM_TABLE_CMD = 8'h5a;
    localparam logic [7:0] READ_UNIQUE_ID_CMD = 8'h4b;

    // header bits sent by the host before data: opcode plus four bytes
    localparam int HDR_BITS = 40;
    localparam int UID_DUMMY_BYTES = 4;
    localparam int ADDR_BYTES = 3;

    // parameter table header contents
    localparam logic [31:0] TBL_SIGNATURE = 32'h50444653;
    localparam logic [7:0] TBL_MINOR_REV = 8'h00;
    localparam logic [7:0] TBL_MAJOR_REV = 8'h01;
    localparam logic [7:0] TBL_HEADER_COUNT = 8'h01;
    localparam logic [7:0] TBL_UNUSED = 8'hff;
    localparam logic [7:0] HDR0_ID = 8'h00;
    localparam logic [7:0] HDR0_LEN_DW = 8'h09;
    localparam logic [7:0] HDR0_TABLE_POINTER = 8'h30;
    localparam logic [7:0] HDR1_LEN_DW = 8'h03;
    localparam logic [7:0] HDR1_TABLE_POINTER = 8'h60;

    // transfer kinds for the host user port
    typedef enum logic {FRF_XFER_UID, FRF_XFER_TABLE} frf_xfer_t;

endpackage : frf_pkg

// ===== design/frf_link_if.sv
// serial flash link: reset pin, select, clock, data in and data out
// assumes one host end and one device end joined by the bench
`timescale 1ns/1ps
`default_nettype none
interface frf_link_if;
    logic rst_n;
    logic cs_n;
    logic sclk;
    logic si;
    logic so;
    logic so_oe;
    logic so_line;

    // data out is pulled high while the device does not drive it
    assign so_line = so_oe ? so : 1'b1;

    modport dev (
        input rst_n,
        input cs_n,
        input sclk,
        input si,
        output so,
        output so_oe
    );

    modport host (
        output rst_n,
        output cs_n,
        output sclk,
        output si,
        input so_line
    );
endinterface : frf_link_if
`default_nettype wire

// ===== design/frf_host.sv
// host end: drives the reset pin, select, serial clock and data in
// assumes the device end is joined through frf_link_if
`timescale 1ns/1ps
`default_nettype none
module frf_host #(
    parameter int SCLK_HALF = frf_pkg::SCLK_HALF_CYC,
    parameter int LONG_RECOVERY_CYC = frf_pkg::RESET_RECOVERY_LONG_CYC
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    frf_link_if.host link,
    input wire logic i_reset_req,
    input wire logic i_long_recovery,
    input wire logic i_start,
    input wire frf_pkg::frf_xfer_t i_kind,
    input wire logic [23:0] i_addr,
    input wire logic [15:0] i_len,
    output logic o_busy,
    output logic o_done,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    input wire logic i_rx_ready
);

    // the serial input must settle through two stages within a half period
    initial begin
        if (SCLK_HALF < 4 || SCLK_HALF > 255 || LONG_RECOVERY_CYC < 1 ||
            LONG_RECOVERY_CYC >= 2**24) begin
            $error("host timing parameter out of range");
        end
    end

    typedef enum logic [2:0] {
        H_RST, H_REC, H_IDLE, H_XFER, H_DESEL
    } frf_host_st_t;

    typedef struct packed {
        frf_host_st_t st;
        logic so_s1;
        logic so_s2;
        logic rst_n;
        logic cs_n;
        logic sclk;
        logic si;
        logic [23:0] cnt;
        logic [23:0] wait_cyc;
        logic [7:0] div;
        logic [5:0] pulse;
        logic [2:0] bit_cnt;
        logic [39:0] tx;
        logic [7:0] rx_sh;
        logic [15:0] left;
        logic [1:0][7:0] buf_mem;
        logic buf_wp;
        logic buf_rp;
        logic [1:0] buf_cnt;
        logic done;
    } frf_host_state_t;

    frf_host_state_t q, d;
    logic tick;
    logic pop;

    assign tick = q.div == 8'(SCLK_HALF - 1);
    assign pop = o_rx_valid && i_rx_ready;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        d.so_s1 = link.so_line;
        d.so_s2 = q.so_s1;
        d.done = 1'b0;
        d.div = tick ? 8'h0 : q.div + 8'h1;
        if (pop) begin
            d.buf_rp = !q.buf_rp;
            d.buf_cnt = q.buf_cnt - 2'h1;
        end
        case (q.st)
            H_RST: begin
                d.cnt = q.cnt + 24'h1;
                if (q.cnt == 24'(frf_pkg::RESET_LOW_CYC - 1)) begin
                    d.rst_n = 1'b1;
                    d.st = H_REC;
                    d.cnt = 24'h0;
                end
            end
            H_REC: begin
                // recovery wait also covers the high-to-select time
                d.cnt = q.cnt + 24'h1;
                if (q.cnt >= q.wait_cyc - 24'h1 && q.cnt >=
                    24'(frf_pkg::RESET_HIGH_TO_SELECT_CYC - 1)) begin
                    d.st = H_IDLE;
                end
            end
            H_IDLE: begin
                if (i_start && i_len != 16'h0) begin
                    d.tx = (i_kind == frf_pkg::FRF_XFER_TABLE)
                         ? {frf_pkg::READ_PARAM_TABLE_CMD, i_addr, 8'h00}
                         : {frf_pkg::READ_UNIQUE_ID_CMD, 32'h0};
                    d.si = d.tx[39];
                    d.cs_n = 1'b0;
                    d.left = i_len;
                    d.pulse = 6'h0;
                    d.bit_cnt = 3'h0;
                    d.div = 8'h0;
                    d.st = H_XFER;
                end
            end
            H_XFER: begin
                if (tick && !q.sclk) begin
                    // hold the next data byte until the buffer has room
                    if (q.pulse != 6'(frf_pkg::HDR_BITS) ||
                        q.bit_cnt != 3'h0 || q.buf_cnt != 2'h2) begin
                        d.sclk = 1'b1;
                    end else begin
                        d.div = q.div;
                    end
                end else if (tick) begin
                    d.sclk = 1'b0;
                    if (q.pulse != 6'(frf_pkg::HDR_BITS)) begin
                        d.tx = {q.tx[38:0], 1'b0};
                        d.si = q.tx[38];
                        d.pulse = q.pulse + 6'h1;
                    end else begin
                        d.rx_sh = {q.rx_sh[6:0], q.so_s2};
                        d.bit_cnt = q.bit_cnt + 3'h1;
                        if (q.bit_cnt == 3'h7) begin
                            d.buf_mem[q.buf_wp] = {q.rx_sh[6:0], q.so_s2};
                            d.buf_wp = !q.buf_wp;
                            d.buf_cnt = d.buf_cnt + 2'h1;
                            d.left = q.left - 16'h1;
                            if (q.left == 16'h1) begin
                                d.st = H_DESEL;
                            end
                        end
                    end
                end
            end
            H_DESEL: begin
                d.cs_n = 1'b1;
                d.si = 1'b0;
                if (tick) begin
                    d.done = 1'b1;
                    d.st = H_IDLE;
                end
            end
            default: d.st = H_IDLE;
        endcase
        // a reset request cuts any transfer short
        if (i_reset_req) begin
            d.st = H_RST;
            d.rst_n = 1'b0;
            d.cs_n = 1'b1;
            d.sclk = 1'b0;
            d.si = 1'b0;
            d.cnt = 24'h0;
            d.wait_cyc = i_long_recovery ? 24'(LONG_RECOVERY_CYC)
                                         : 24'(frf_pkg::RESET_RECOVERY_CYC);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '0;
            q.st <= H_REC;
            q.rst_n <= 1'b1;
            q.cs_n <= 1'b1;
            q.so_s1 <= 1'b1;
            q.so_s2 <= 1'b1;
            q.wait_cyc <= 24'(frf_pkg::RESET_RECOVERY_CYC);
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign link.rst_n = q.rst_n;
    assign link.cs_n = q.cs_n;
    assign link.sclk = q.sclk;
    assign link.si = q.si;
    assign o_busy = q.st != H_IDLE;
    assign o_done = q.done;
    assign o_rx_valid = q.buf_cnt != 2'h0;
    assign o_rx_data = q.buf_mem[q.buf_rp];

endmodule : frf_host
`default_nettype wire

// ===== sim/frf_link_props.sv
// checker for the link between host end and device end
// assumes the bench hands in the link signals plus the host clock and reset
`timescale 1ns/1ps
`default_nettype none
module frf_link_props (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic so_oe
);
    logic [9:0] hi_q;
    logic [9:0] lo_q;
    ////////////////////////////////////////////////////////////////////////
    // saturating counts of reset pin high and low time, enough for 30 us
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            hi_q <= 10'h000;
            lo_q <= 10'h000;
        end else begin
            hi_q <= !rst_n ? 10'h000 : hi_q + {9'h000, hi_q != 10'h3ff};
            lo_q <= rst_n ? 10'h000 : lo_q + {9'h000, lo_q != 10'h3ff};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    // sync lag of a few cycles is allowed before data out lets go
    reset_quiet_a: assert property (
        !rst_n [*5] |-> !so_oe) else $error("data out driven in reset");
    release_quiet_a: assert property (
        cs_n [*6] |-> !so_oe) else $error("data out driven after end");
    select_gap_a: assert property (
        $fell(cs_n) |-> hi_q >= frf_pkg::RESET_HIGH_TO_SELECT_CYC)
        else $error("select too soon after reset pin high");
    recovery_wait_a: assert property (
        $fell(cs_n) |-> hi_q >= frf_pkg::RESET_RECOVERY_CYC)
        else $error("command before recovery time");
    low_width_a: assert property (
        $rose(rst_n) |-> lo_q >= frf_pkg::RESET_LOW_CYC)
        else $error("reset pin pulse too short");
    select_idle_a: assert property (
        cs_n |-> !sclk) else $error("serial clock high while idle");
    header_quiet_a: assert property (
        $fell(cs_n) |-> !so_oe [*8]) else $error("data out in header");
    si_steady_a: assert property (
        sclk && $past(sclk) |-> $stable(si)) else $error("si moved");
    reset_ends_a: assert property (
        $fell(rst_n) |-> ##[0:2] cs_n) else $error("select kept in reset");
endmodule : frf_link_props
`default_nettype wire

// ===== sim/frf_testbench.sv
// bench joining host end and device end through the link interface
// assumes the design package, interface and both ends are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    bad_count++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module testbench;
    localparam logic [127:0] UID = 128'h00112233445566778899aabbccddeeff;
    localparam logic [7:0] VEND = 8'h5e; // arbitrary value
    logic clk = 1'b0, nrst = 1'b0, pe_busy = 1'b0, pe_abort, vol_reset;
    logic in_reset, dev_busy, reset_req = 1'b0, long_rec = 1'b0;
    logic start = 1'b0, busy, done, rx_valid, rx_ready = 1'b1;
    logic stall = 1'b0, in_seen = 1'b0;
    logic [23:0] addr = 24'h000000;
    logic [15:0] len = 16'h0001;
    logic [7:0] rx_data;
    frf_pkg::frf_xfer_t kind = frf_pkg::FRF_XFER_TABLE;
    int bad_count = 0, tests_run = 0, ab_n = 0, vr_n = 0, cyc = 0;
    logic [7:0] q [$];
    frf_link_if link();
    frf_device #(.UNIQUE_ID(UID), .VENDOR_ID(VEND)) i_frf_device (
        .i_clk(clk), .i_nrst(nrst), .link(link), .i_pe_busy(pe_busy),
        .o_pe_abort(pe_abort), .o_vol_reset(vol_reset),
        .o_in_reset(in_reset), .o_busy(dev_busy));
    frf_host #(.LONG_RECOVERY_CYC(400)) i_frf_host (
        .i_clk(clk), .i_nrst(nrst), .link(link), .i_reset_req(reset_req),
        .i_long_recovery(long_rec), .i_start(start), .i_kind(kind),
        .i_addr(addr), .i_len(len), .o_busy(busy), .o_done(done),
        .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready));
    frf_link_props i_frf_link_props (.i_clk(clk), .i_nrst(nrst),
        .rst_n(link.rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
        .si(link.si), .so_oe(link.so_oe));
    ////////////////////////////////////////////////////////////////////////
    always #50 clk = ~clk;
    // receiver stalls 100 of every 200 cycles so the buffer fills up
    always @(negedge clk) begin
        cyc <= cyc + 1;
        rx_ready <= !stall || (cyc % 200 < 100);
    end
    // collect popped bytes and count reset side pulses
    always @(posedge clk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) q.push_back(rx_data);
        if (pe_abort === 1'b1) ab_n++;
        if (vol_reset === 1'b1) vr_n++;
        if (in_reset === 1'b1) in_seen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] tbl(input int a);
        logic [7:0] t [0:23];
        t = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff,
              8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff,
              VEND, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hff};
        return (a < 24) ? t[a] : 8'hff;
    endfunction : tbl
    task automatic end_sim();
        if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    // start a transfer once idle; no wait, so a reset can cut it short
    task automatic launch(input frf_pkg::frf_xfer_t k, input logic [23:0] a,
                          input logic [15:0] n);
        int w;
        w = 0;
        while (busy !== 1'b0 && w < 5000) begin
            @(negedge clk);
            w++;
        end
        q.delete();
        kind = k;
        addr = a;
        len = n;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
    endtask : launch
    task automatic xfer(input frf_pkg::frf_xfer_t k, input logic [23:0] a,
                        input logic [15:0] n);
        int w, dn;
        w = 0;
        dn = 0;
        launch(k, a, n);
        // a stalled receiver may still drain bytes after the host is done
        while ((q.size() < int'(n) || busy !== 1'b0) && w < 20000) begin
            @(negedge clk);
            if (done === 1'b1) dn++;
            w++;
        end
        `CHK("byte count", int'(n), q.size())
        `CHK("done pulses", 1, dn)
        `CHK("device idle", 1'b0, dev_busy)
    endtask : xfer
    // pulse the reset pin and time its low width and the recovery
    task automatic do_reset(input logic lg, input int rec);
        int lo, hi;
        lo = 0;
        hi = 0;
        reset_req = 1'b1;
        long_rec = lg;
        @(negedge clk);
        reset_req = 1'b0;
        while (link.rst_n !== 1'b1 && lo < 500) begin
            if (lo > 4) `CHK("so_oe", 1'b0, link.so_oe)
            @(negedge clk);
            lo++;
        end
        while (busy !== 1'b0 && hi < 2000) begin
            @(negedge clk);
            hi++;
        end
        `CHK("low width", 1'b1, lo >= frf_pkg::RESET_LOW_CYC)
        `CHK("recovery", 1'b1, hi >= rec)
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////
    task automatic t_table();
        stall = 1'b1;
        xfer(frf_pkg::FRF_XFER_TABLE, 24'h000000, 16'h001a);
        stall = 1'b0;
        for (int i = 0; i < 26; i++)
            `CHK("table", tbl(i), q[i])
        `CHK("unused", 8'hff, q[23])
    endtask : t_table
    task automatic t_mid();
        xfer(frf_pkg::FRF_XFER_TABLE, 24'h000013, 16'h0002);
        `CHK("mid 13", frf_pkg::HDR1_LEN_DW, q[0])
        `CHK("mid 14", frf_pkg::HDR1_TABLE_POINTER, q[1])
    endtask : t_mid
    task automatic t_uid();
        xfer(frf_pkg::FRF_XFER_UID, 24'h000000, 16'h0010);
        for (int i = 0; i < 16; i++)
            `CHK("uid", UID[127 - 8 * i -: 8], q[i])
    endtask : t_uid
    task automatic t_reset();
        int w;
        w = 0;
        pe_busy = 1'b1;
        launch(frf_pkg::FRF_XFER_TABLE, 24'h000000, 16'h0010);
        while (q.size() < 1 && w < 2000) begin
            @(negedge clk);
            w++;
        end
        do_reset(1'b0, frf_pkg::RESET_RECOVERY_CYC);
        `CHK("abort", 1, ab_n)
        `CHK("volatile", 1, vr_n)
        `CHK("in reset", 1'b1, in_seen)
        pe_busy = 1'b0;
        do_reset(1'b1, 400);
        `CHK("no abort", 1, ab_n)
        `CHK("volatile 2", 2, vr_n)
    endtask : t_reset
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        t_table();
        t_mid();
        t_uid();
        t_reset();
        t_mid();
        end_sim();
    end
    // watchdog well past the expected run of about 6000 cycles
    initial begin
        #4000000;
        bad_count++;
        end_sim();
    end
endmodule : testbench
`default_nettype wire
